// File: verilog/dpc_pkg.sv
// Package holding constants, types and carriers for the converter control block
package dpc_pkg;

  // ==========================================================================
  // Sizes and cycle counts
  localparam int RESULT_W    = 12;   // Result width in bits
  localparam int ACQ_CYCLES  = 6;    // Internally timed acquisition, conversion clocks
  localparam int CONV_CYCLES = 12;   // Conversion length, conversion clocks
  localparam int INT_CLK_DIV = 10;   // Core clocks per internal conversion clock
  localparam int BYTE_W      = 8;    // Data bus width

  // ==========================================================================
  // Result byte layout on the bus
  localparam int RES_MSB     = 11;   // Sign / top result bit
  localparam int HI_NIB_LO   = 8;    // First bit of the high nibble
  localparam int BUS_NIB_LO  = 4;    // First upper bus line during high byte

  // ==========================================================================
  // Power and clock mode codes
  localparam logic [1:0] MODE_NORM_EXT = 2'h0;  // Normal, external clock
  localparam logic [1:0] MODE_NORM_INT = 2'h1;  // Normal, internal clock
  localparam logic [1:0] MODE_STBY_PD  = 2'h2;  // Standby power-down
  localparam logic [1:0] MODE_FULL_PD  = 2'h3;  // Full power-down
  localparam logic       CLK_EXT_RST   = 1'h0;  // External clock after reset

  // ==========================================================================
  // Control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       powerClockSelHi;    // Bit 7
    logic       powerClockSelLo;    // Bit 6
    logic       externalAcquireSel; // Bit 5
    logic       rangeMagnitudeSel;  // Bit 4
    logic       bipolarSel;         // Bit 3
    logic [2:0] channelSel;         // Bits 2..0
  } dpc_ctrl_t;

  localparam dpc_ctrl_t CTRL_RST = 8'h00;  // Reset control byte

  // Parallel bus strobes
  typedef struct packed {
    logic csN;              // Chip select, low active
    logic wrN;              // Write strobe, low active
    logic rdN;              // Read strobe, low active
    logic highByteSelect;   // High result byte when set
  } dpc_bus_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_ACQ_INT = 4'h2,
    ST_ACQ_EXT = 4'h4,
    ST_CONV    = 4'h8
  } dpc_state_t;

endpackage

// File: verilog/dpc_sar.sv
// Successive approximation register stepping one bit per conversion clock
`timescale 1ns/1ps
`default_nettype none
module dpc_sar
(
  input  wire logic                          core_clk,  // Core clock
  input  wire logic                          reset_n,   // Async reset, low active
  input  wire logic                          start,     // Begin a conversion
  input  wire logic                          abort,     // Drop the running conversion
  input  wire logic                          tick,      // Conversion clock pulse
  input  wire logic                          compHigh,  // Input at or above trial
  output logic [dpc_pkg::RESULT_W-1:0]       trial,     // Trial code to the DAC
  output logic                               busy,      // Conversion running
  output logic                               donePulse, // One cycle at completion
  output logic [dpc_pkg::RESULT_W-1:0]       result     // Final code
);
  import dpc_pkg::*;

  typedef struct packed {
    logic                busy;
    logic [3:0]          pos;
    logic [RESULT_W-1:0] trial;
    logic                done;
    logic [RESULT_W-1:0] result;
  } dpc_sar_st_t;

  dpc_sar_st_t r;
  dpc_sar_st_t next_r;

  // ==========================================================================
  // Bit decision sequence
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    if (start)
    begin
      // Start from mid-scale, top bit set
      next_r.busy  = 1'b1;
      next_r.pos   = 4'(RES_MSB);
      next_r.trial = {1'b1, {(RESULT_W-1){1'b0}}};
    end
    else if (abort)
    begin
      next_r.busy = 1'b0;
    end
    else if (r.busy && tick)
    begin
      if (!compHigh)
        next_r.trial[r.pos] = 1'b0;
      if (r.pos == 4'h0)
      begin
        next_r.busy   = 1'b0;
        next_r.done   = 1'b1;
        next_r.result = compHigh ? r.trial : (r.trial & {{(RESULT_W-1){1'b1}}, 1'b0});
      end
      else
      begin
        next_r.trial[r.pos-4'h1] = 1'b1;
        next_r.pos = r.pos - 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign trial     = r.trial;
  assign busy      = r.busy;
  assign donePulse = r.done;
  assign result    = r.result;

  // ==========================================================================
  // Checks: ticks seen between start and completion
  logic [4:0] tickSeen;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tickSeen <= 5'h00;
    else if (start)
      tickSeen <= 5'h00;
    else if (r.busy && tick && !abort)
      tickSeen <= tickSeen + 5'h01;
  end

  conv_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    r.done |-> tickSeen == 5'(CONV_CYCLES))
    else $error("conversion did not take twelve conversion clocks");

endmodule
`default_nettype wire

// File: verilog/dpc_adc_control.sv
// Top of the converter control: bus port, sequencer, modes and result read
// ============================================================================
// Overview of operation
// - Acquire bit clear: track from write rise, hold after 6 clocks, convert.
// - Acquire bit set tracks open-ended; later write with it clear converts.
// - Second byte with acquire bit set restarts open-ended tracking.
// - Mode bits of the second external acquisition write are accepted.
// - Every conversion lasts 12 conversion clocks.
// - A write during conversion aborts it and starts a new acquisition.
// - Chip select high ignores strobes and floats the data bus.
// - Selected write captures all eight bus bits as control byte.
// - Bits 7-6 mode, 5 acquire style, 4 range, 3 polarity, 2-0 channel.
// - Polarity and range bits pick 0-5, 0-10, +-5, +-10 volt ranges.
// - Mode codes: normal ext, normal int, standby, full; power-down keeps clock.
// - Channel bits decode as binary channel zero through seven.
// - Read low byte with byte select low, high nibble with it high.
// - High byte upper lines zero if unipolar, copies of bit 11 if bipolar.
// - Result straight binary for unipolar, two's complement for bipolar.
// - Done output falls at completion, rises at first read or new write.
// - After reset: normal mode, external clock, done output high.
// - Soft power-down waits for conversion end; write falling edge wakes.
// - Shutdown pin low forces full power-down and aborts conversion.
`timescale 1ns/1ps
`default_nettype none
module dpc_adc_control
#(
  parameter int CLK_DIV = dpc_pkg::INT_CLK_DIV  // Core clocks per internal clock
)
(
  input  wire logic                      core_clk,          // 20 MHz core clock
  input  wire logic                      reset_n,           // Async reset, low active
  input  wire dpc_pkg::dpc_bus_t         bus,               // Bus strobes
  input  wire logic [dpc_pkg::BYTE_W-1:0] dataIn,           // Data bus input
  output logic [dpc_pkg::BYTE_W-1:0]     dataOut,           // Data bus output
  output logic                           dataOe,            // Data bus drive enable
  output logic                           doneN,             // Done, low active
  input  wire logic                      hardwareShutdownN, // Shutdown pin, low active
  input  wire logic                      extConvClk,        // External conversion clock
  input  wire logic                      compHigh,          // Comparator result
  output logic [dpc_pkg::RESULT_W-1:0]   sarTrial,          // Trial code to the DAC
  output logic                           trackHold,         // High while tracking
  output logic [2:0]                     channelSel,        // Input mux channel
  output logic                           bipolarSel,        // Bipolar range
  output logic                           rangeMagnitudeSel, // Ten volt magnitude
  output logic                           clkInternal,       // Internal clock in use
  output logic [1:0]                     powerMode          // Current power mode code
);
  import dpc_pkg::*;

  typedef struct packed {
    dpc_state_t          st;
    dpc_ctrl_t           ctrl;
    dpc_ctrl_t           wrLatch;
    logic                clkInt;
    logic [1:0]          pwr;
    logic                pdPend;
    logic [1:0]          pdMode;
    logic                doneN;
    logic [RESULT_W-1:0] result;
    logic                prevWr;
    logic                prevRd;
    logic                prevExt;
    logic [7:0]          divCnt;
    logic [2:0]          tickCnt;
    logic [BYTE_W-1:0]   dataOut;
  } dpc_top_st_t;

  dpc_top_st_t r;
  dpc_top_st_t next_r;

  logic                wrAct;
  logic                rdAct;
  logic                wrRise;
  logic                wrFall;
  logic                rdFall;
  logic                tick;
  logic                sarStart;
  logic                sarAbort;
  logic                sarDone;
  logic [RESULT_W-1:0] sarResult;
  logic [RESULT_W-1:0] coded;
  logic [3:0]          upperNib;

  // ==========================================================================
  // Strobe qualification; chip select high masks everything
  assign wrAct  = !bus.csN && !bus.wrN;
  assign rdAct  = !bus.csN && !bus.rdN;
  assign wrRise = r.prevWr && !wrAct;
  assign wrFall = wrAct && !r.prevWr;
  assign rdFall = rdAct && !r.prevRd;

  // Conversion clock: divider or edge of the sampled external clock
  assign tick = r.clkInt ? (r.divCnt == 8'(CLK_DIV-1)) : (extConvClk && !r.prevExt);

  // Bipolar codes flip the top bit of the offset code
  assign coded = r.ctrl.bipolarSel ? (sarResult ^ {1'b1, {(RESULT_W-1){1'b0}}}) : sarResult;
  assign upperNib = r.ctrl.bipolarSel ? {4{r.result[RES_MSB]}} : 4'h0;

  // ==========================================================================
  // Sequencer and mode logic
  always_comb
  begin
    next_r = r;
    next_r.prevWr  = wrAct;
    next_r.prevRd  = rdAct;
    next_r.prevExt = extConvClk;
    if (wrAct)
      next_r.wrLatch = dataIn;
    // Divider keeps running; harmless while the external clock is chosen
    if (r.divCnt == 8'(CLK_DIV-1))
      next_r.divCnt = 8'h00;
    else
      next_r.divCnt = r.divCnt + 8'h01;
    if (wrFall)
      next_r.pwr = MODE_NORM_EXT;
    if (rdFall)
      next_r.doneN = 1'b1;
    case (r.st)
      ST_IDLE:
      begin
        next_r.tickCnt = 3'h0;
      end
      ST_ACQ_INT:
      begin
        if (tick)
        begin
          if (r.tickCnt == 3'(ACQ_CYCLES-1))
          begin
            next_r.st = ST_CONV;
            next_r.tickCnt = 3'h0;
          end
          else
            next_r.tickCnt = r.tickCnt + 3'h1;
        end
      end
      ST_ACQ_EXT:
      begin
        next_r.tickCnt = 3'h0;
      end
      ST_CONV:
      begin
        if (sarDone)
        begin
          next_r.st = ST_IDLE;
          next_r.result = coded;
          next_r.doneN = 1'b0;
          if (r.pdPend)
          begin
            next_r.pwr = r.pdMode;
            next_r.pdPend = 1'b0;
          end
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase
    // A committed control byte starts a new acquisition, or converts at once after external tracking
    if (wrRise && hardwareShutdownN)
    begin
      next_r.ctrl = r.wrLatch;
      next_r.tickCnt = 3'h0;
      if (!(r.st == ST_CONV && sarDone))
        next_r.doneN = 1'b1;
      if (!r.wrLatch.powerClockSelHi)
      begin
        next_r.clkInt = r.wrLatch.powerClockSelLo;
        next_r.pdPend = 1'b0;
      end
      else
      begin
        next_r.pdPend = 1'b1;
        next_r.pdMode = {r.wrLatch.powerClockSelHi, r.wrLatch.powerClockSelLo};
      end
      if (r.wrLatch.externalAcquireSel)
        next_r.st = ST_ACQ_EXT;
      else if (r.st == ST_ACQ_EXT)
        next_r.st = ST_CONV;
      else
        next_r.st = ST_ACQ_INT;
    end
    // Hardware shutdown overrides state, power mode and pending power-down
    if (!hardwareShutdownN)
    begin
      next_r.st = ST_IDLE;
      next_r.pwr = MODE_FULL_PD;
      next_r.pdPend = 1'b0;
    end
    // Output register; one cycle behind the byte select
    if (bus.highByteSelect)
      next_r.dataOut = {upperNib, r.result[RES_MSB:HI_NIB_LO]};
    else
      next_r.dataOut = r.result[BYTE_W-1:0];
  end

  // State register with power-up defaults
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= CTRL_RST;
      r.clkInt <= CLK_EXT_RST;
      r.pwr <= MODE_NORM_EXT;
      r.doneN <= 1'b1;
      r.prevWr <= 1'b0;
      r.prevRd <= 1'b0;
    end
    else
      r <= next_r;
  end

  // ==========================================================================
  // Conversion engine
  assign sarStart = (next_r.st == ST_CONV) && (r.st != ST_CONV);
  assign sarAbort = (r.st == ST_CONV) && (next_r.st != ST_CONV) && !sarDone;

  dpc_sar u_sar
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .start     (sarStart),
    .abort     (sarAbort),
    .tick      (tick && (r.st == ST_CONV)),
    .compHigh  (compHigh),
    .trial     (sarTrial),
    .busy      (),
    .donePulse (sarDone),
    .result    (sarResult)
  );

  // Outputs
  assign dataOut           = r.dataOut;
  assign dataOe            = rdAct;
  assign doneN             = r.doneN;
  assign trackHold         = (r.st == ST_ACQ_INT) || (r.st == ST_ACQ_EXT);
  assign channelSel        = r.ctrl.channelSel;
  assign bipolarSel        = r.ctrl.bipolarSel;
  assign rangeMagnitudeSel = r.ctrl.rangeMagnitudeSel;
  assign clkInternal       = r.clkInt;
  assign powerMode         = r.pwr;

  // ==========================================================================
  // Checks
  bus_float_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.csN |-> !dataOe)
    else $error("data bus driven while deselected");

  done_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == ST_CONV && sarDone) |=> !doneN && r.result == $past(coded))
    else $error("done or result missing at completion");

  done_rise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rdFall && !sarDone) |=> doneN)
    else $error("done not released on read");

  acq_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == ST_ACQ_INT && next_r.st == ST_CONV) |-> tick && r.tickCnt == 3'(ACQ_CYCLES-1))
    else $error("internal acquisition not six clocks");

  ext_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == ST_ACQ_EXT && !wrRise && hardwareShutdownN) |=> r.st == ST_ACQ_EXT)
    else $error("external acquisition ended without a write");

  abort_conv_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == ST_CONV && wrRise && hardwareShutdownN && !r.wrLatch.externalAcquireSel)
      |=> r.st == ST_ACQ_INT)
    else $error("write during conversion did not restart acquisition");

  shutdown_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !hardwareShutdownN |=> powerMode == MODE_FULL_PD && r.st == ST_IDLE)
    else $error("shutdown pin not obeyed");

  pd_defer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == ST_CONV && $past(r.st) == ST_CONV && hardwareShutdownN) |->
      powerMode == $past(r.pwr) || $past(wrFall))
    else $error("power mode changed during conversion");

  hi_byte_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.highByteSelect |=> dataOut[BYTE_W-1:BUS_NIB_LO] ==
      ($past(r.ctrl.bipolarSel) ? {4{$past(r.result[RES_MSB])}} : 4'h0))
    else $error("high byte upper lines wrong");

  clk_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wrRise && r.wrLatch.powerClockSelHi) |=> clkInternal == $past(r.clkInt))
    else $error("power-down write changed clock source");

endmodule
`default_nettype wire

// File: verif/dpc_host_model.sv
// Host processor model that drives the parallel bus of the converter control
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model
(
  input  wire logic              core_clk,   // Core clock
  output var  dpc_pkg::dpc_bus_t bus,        // Bus strobes
  output logic [7:0]             busWire,    // Resolved data lines
  input  wire logic [7:0]        dataOut,    // Device data output
  input  wire logic              dataOe,     // Device drive enable
  output logic                   readStrobe, // One cycle per finished read
  output logic [7:0]             readData    // Byte taken at a read
);
  import dpc_pkg::*;
  logic [7:0] hostDrv;
  logic       hostOe;
  logic [7:0] floatPat = 8'h5A;

  // ==========================================================================
  // Bus resolution
  // Released lines toggle every cycle, so a stale byte can never pass
  always @(posedge core_clk) floatPat <= ~floatPat;
  assign busWire = dataOe ? dataOut : (hostOe ? hostDrv : floatPat);

  // Idle bus at time zero
  initial
  begin
    bus = 4'hE;
    hostOe = 1'b0;
    hostDrv = 8'h00;
    readStrobe = 1'b0;
    readData = 8'h00;
  end

  // ==========================================================================
  // Bus cycles, all entered just after a rising edge
  // Write holds the byte for one edge, then commits by raising the strobe
  task automatic writeCtrl(input logic [7:0] b);
    hostDrv = b;
    hostOe = 1'b1;
    bus.csN = 1'b0;
    bus.wrN = 1'b0;
    @(posedge core_clk);
    #5;
    bus.wrN = 1'b1;
    bus.csN = 1'b1;
    hostOe = 1'b0;
    @(posedge core_clk);
    #5;
  endtask

  // Read waits one cycle for the registered byte before taking it
  task automatic readByte(input logic hbs);
    bus.csN = 1'b0;
    bus.rdN = 1'b0;
    bus.highByteSelect = hbs;
    repeat (2) @(posedge core_clk);
    readData <= busWire;
    readStrobe <= 1'b1;
    #5;
    bus.csN = 1'b1;
    bus.rdN = 1'b1;
    @(posedge core_clk);
    readStrobe <= 1'b0;
    #5;
  endtask

  // Strobes with chip select high; reports whether the device drove the bus
  task automatic strobeIdle(input logic [7:0] b, output logic sawOe);
    sawOe = 1'b0;
    hostDrv = b;
    hostOe = 1'b1;
    bus.wrN = 1'b0;
    bus.rdN = 1'b0;
    repeat (3)
    begin
      @(posedge core_clk);
      sawOe = sawOe | dataOe;
    end
    #5;
    bus.wrN = 1'b1;
    bus.rdN = 1'b1;
    hostOe = 1'b0;
    @(posedge core_clk);
    #5;
  endtask
endmodule
`default_nettype wire

// File: verif/dpc_adc_control_bench.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dpc_adc_control_bench;
  import dpc_pkg::*;
  localparam int DIV = 2;
  logic core_clk, reset_n, hardwareShutdownN, extConvClk, compHigh, dataOe, doneN;
  logic readStrobe, trackHold, bipolarSel, rangeMagnitudeSel, clkInternal, saw;
  dpc_bus_t bus;
  logic [7:0] busWire, dataOut, readData;
  logic [11:0] sarTrial, target;
  logic [2:0] channelSel;
  logic [1:0] powerMode;
  logic [7:0] expQ[$];
  int n_mismatch, checks, n;

  dpc_adc_control #(.CLK_DIV(DIV)) dut
  (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .bus               (bus),
    .dataIn            (busWire),
    .dataOut           (dataOut),
    .dataOe            (dataOe),
    .doneN             (doneN),
    .hardwareShutdownN (hardwareShutdownN),
    .extConvClk        (extConvClk),
    .compHigh          (compHigh),
    .sarTrial          (sarTrial),
    .trackHold         (trackHold),
    .channelSel        (channelSel),
    .bipolarSel        (bipolarSel),
    .rangeMagnitudeSel (rangeMagnitudeSel),
    .clkInternal       (clkInternal),
    .powerMode         (powerMode)
  );
  dpc_host_model host
  (
    .core_clk   (core_clk),
    .bus        (bus),
    .busWire    (busWire),
    .dataOut    (dataOut),
    .dataOe     (dataOe),
    .readStrobe (readStrobe),
    .readData   (readData)
  );

  // ==========================================================================
  // Clocks and analog side
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // External conversion clock, one rise every two core cycles
  initial
  begin
    extConvClk = 1'b0;
    forever
    begin
      @(posedge core_clk);
      #5 extConvClk = ~extConvClk;
    end
  end
  // Ideal comparator: the search settles on the target code
  assign compHigh = (sarTrial <= target);

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #5;
  endtask

  task automatic waitDone(output int c);
    c = 0;
    while (doneN !== 1'b0 && c < 400)
    begin
      cyc(1);
      c++;
    end
  endtask

  // Queue both result bytes, then read them low byte first
  task automatic readBack(input logic [7:0] ctrl);
    logic [11:0] res;
    res = ctrl[3] ? {~target[11], target[10:0]} : target;
    expQ.push_back(res[7:0]);
    expQ.push_back({ctrl[3] ? {4{res[11]}} : 4'h0, res[11:8]});
    host.readByte(1'b0);
    host.readByte(1'b1);
    chk(doneN === 1'b1, "done not released by read");
  endtask

  task automatic convert(input logic [7:0] ctrl, input logic [11:0] t);
    target = t;
    host.writeCtrl(ctrl);
    cyc(1);
    chk(channelSel === ctrl[2:0] && bipolarSel === ctrl[3], "channel or polarity");
    chk(rangeMagnitudeSel === ctrl[4], "range");
    chk(powerMode === MODE_NORM_EXT, "wake");
    waitDone(n);
    chk(doneN === 1'b0, "no completion");
    readBack(ctrl);
  endtask

  task automatic results;
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watcher: each finished read takes the oldest expected byte
  always @(posedge core_clk)
  if (readStrobe === 1'b1)
  begin
    if (expQ.size() == 0)
      chk(1'b0, "unexpected read");
    else
      chk(readData === expQ.pop_front(), "read byte wrong");
  end

  // Watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    #(50 * 20000);
    n_mismatch++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    hardwareShutdownN = 1'b1;
    target = 12'h000;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(32'h43C7));
    repeat (20) @(posedge core_clk);
    #5 reset_n = 1'b1;
    cyc(1);
    chk(doneN === 1'b1 && powerMode === MODE_NORM_EXT, "reset");
    chk(clkInternal === CLK_EXT_RST, "reset clock");
    // Every channel and range code, external clock, internal acquisition
    for (int i = 0; i < 8; i++)
      convert({3'h0, 2'(i), 3'(i)}, 12'($urandom));
    chk(clkInternal === 1'b0, "external clock lost");
    // Internal clock: acquisition and conversion lengths
    convert(8'h40, 12'h800);
    target = 12'($urandom);
    host.writeCtrl(8'h47);
    cyc(1);
    n = 0;
    while (trackHold === 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 5 * DIV && n <= 6 * DIV + 1, "acquisition length");
    waitDone(n);
    chk(n >= 11 * DIV && n <= 14 * DIV, "conversion length");
    readBack(8'h47);
    // Open-ended tracking, restart, then convert with a standby request
    host.writeCtrl(8'h65);
    cyc(40);
    chk(trackHold === 1'b1 && doneN === 1'b1, "open tracking");
    host.writeCtrl(8'h65);
    cyc(40);
    chk(trackHold === 1'b1 && doneN === 1'b1, "restarted tracking");
    target = 12'($urandom);
    host.writeCtrl(8'h85);
    cyc(1);
    chk(trackHold === 1'b0, "conversion not started");
    waitDone(n);
    readBack(8'h85);
    chk(powerMode === MODE_STBY_PD && clkInternal === 1'b1, "standby");
    convert(8'hCA, 12'($urandom));
    chk(powerMode === MODE_FULL_PD && clkInternal === 1'b1, "full power-down");
    // Abort in mid-conversion, then read the result twice
    host.writeCtrl(8'h43);
    cyc(20);
    chk(trackHold === 1'b0 && doneN === 1'b1, "not converting");
    target = 12'($urandom);
    host.writeCtrl(8'h5C);
    cyc(1);
    chk(trackHold === 1'b1 && channelSel === 3'h4 && doneN === 1'b1, "abort");
    waitDone(n);
    readBack(8'h5C);
    readBack(8'h5C);
    // Shutdown pin in mid-conversion; writes ignored meanwhile
    host.writeCtrl(8'h41);
    cyc(20);
    hardwareShutdownN = 1'b0;
    cyc(2);
    chk(powerMode === MODE_FULL_PD && trackHold === 1'b0, "shutdown");
    host.writeCtrl(8'h06);
    cyc(60);
    chk(doneN === 1'b1 && channelSel === 3'h1, "write during shutdown");
    hardwareShutdownN = 1'b1;
    host.strobeIdle(8'h07, saw);
    chk(saw === 1'b0 && channelSel === 3'h1 && powerMode === MODE_FULL_PD, "deselect");
    convert(8'h0F, 12'($urandom));
    // Done released by a new write instead of a read
    host.writeCtrl(8'h00);
    waitDone(n);
    host.writeCtrl(8'h01);
    cyc(1);
    chk(doneN === 1'b1, "done not released by write");
    results();
  end
endmodule
`default_nettype wire
